// File: rtl/lfg_tile.sv
// Logic tile: three slices of two tables each, with wide muxes and a shift chain.
`timescale 1ns/1ps
`default_nettype none
module lfg_tile #(
   parameter logic [15:0] INIT_ROM = lfg_pkg::INIT_ZERO
) (
   // Clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   // Mode of the four left-hand tables and the right-hand pair
   input  wire logic [1:0]  i_left_mode,
   input  wire logic [1:0]  i_right_mode,
   // Selects, one nibble each: left primaries (shared by both left slices), left secondaries, right primary, right secondary
   input  wire logic [15:0] i_lut_select_inputs,
   output logic [3:0]       o_lut_result,
   // Wide-function selects
   input  wire logic [1:0]  i_wide_sel,
   output logic             o_wide5_result,
   output logic             o_wide6_result,
   // Left-hand memory write and dual-port read
   input  wire logic [1:0]  i_we,
   input  wire logic        i_wdata,
   input  wire logic [3:0]  i_waddr,
   input  wire logic [3:0]  i_rd2_addr,
   output logic             o_rd2_data,
   // Shift chain across the four left-hand tables of this tile
   input  wire logic        i_shift_en,
   input  wire logic        i_shift_cascade_in,
   input  wire logic [5:0]  i_delay_sel,
   output logic             o_delay_out,
   output logic             o_shift_cascade_out
);
   localparam int N = lfg_pkg::TILE_LUTS;
   logic [N-1:0] res;
   logic [N-1:0] casc_out;
   logic [N-1:0] casc_in;
   logic [N-1:0] rd2;
   logic [N-1:0] we_vec;
   logic [N-1:0] chain_tap;
   logic [3:0]   sel_vec [N];
   logic         chain;

   // Four left-hand tables (two slices); in shift mode they all join the chain.
   assign chain = (i_left_mode == lfg_pkg::MODE_SHIFT);
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_lut
         assign casc_in[g] = (g == 0) ? i_shift_cascade_in : casc_out[(g == 0) ? 0 : g-1];
         assign we_vec[g]  = chain ? i_shift_en : i_we[g % 2];
         assign sel_vec[g] = chain ? i_delay_sel[3:0] : i_lut_select_inputs[(g%2)*4 +: 4];
         lfg_lut #(.LEFT_HAND(1'b1), .INIT(INIT_ROM)) u_lut (
            .i_ref_clk           (i_ref_clk),
            .i_rst               (i_rst),
            .i_mode              (i_left_mode),
            .i_lut_select_inputs (sel_vec[g]),
            .o_lut_result        (chain_tap[g]),
            .i_we                (we_vec[g]),
            .i_wdata             (i_wdata),
            .i_waddr             (i_waddr),
            .i_shift_cascade_in  (casc_in[g]),
            .o_shift_cascade_out (casc_out[g]),
            .i_rd2_addr          (i_rd2_addr),
            .o_rd2_data          (rd2[g])
         );
      end
   endgenerate

   // Two right-hand tables, ROM or logic only.
   generate
      for (g = 0; g < 2; g++) begin : g_right
         lfg_lut #(.LEFT_HAND(1'b0), .INIT(INIT_ROM)) u_lut (
            .i_ref_clk           (i_ref_clk),
            .i_rst               (i_rst),
            .i_mode              (i_right_mode),
            .i_lut_select_inputs (i_lut_select_inputs[8+g*4 +: 4]),
            .o_lut_result        (res[2+g]),
            .i_we                (1'b0),
            .i_wdata             (1'b0),
            .i_waddr             (4'h0),
            .i_shift_cascade_in  (1'b0),
            .o_shift_cascade_out (),
            .i_rd2_addr          (4'h0),
            .o_rd2_data          ()
         );
      end
   endgenerate

   assign res[1:0]            = chain_tap[1:0];
   assign o_lut_result        = res;
   assign o_rd2_data          = rd2[0];
   assign o_delay_out         = chain_tap[i_delay_sel[5:4]];
   assign o_shift_cascade_out = casc_out[N-1];

   // Wide muxes combine table outputs into five- and six-input functions.
   assign o_wide5_result = i_wide_sel[0] ? res[1] : res[0];
   assign o_wide6_result = i_wide_sel[1] ? (i_wide_sel[0] ? res[3] : res[2]) : o_wide5_result;

   property p_link1;
      @(posedge i_ref_clk) disable iff (i_rst)
      (chain && i_shift_en) ##1 (chain && i_delay_sel[3:0] == 4'h0)
         |-> chain_tap[1] == $past(casc_out[0]);
   endproperty
   a_link1: assert property (p_link1) else $error("Second table missed the carry.");

   property p_link2;
      @(posedge i_ref_clk) disable iff (i_rst)
      (chain && i_shift_en) ##1 (chain && i_delay_sel[3:0] == 4'h0)
         |-> chain_tap[2] == $past(casc_out[1]);
   endproperty
   a_link2: assert property (p_link2) else $error("Third table missed the carry.");

   property p_link3;
      @(posedge i_ref_clk) disable iff (i_rst)
      (chain && i_shift_en) ##1 (chain && i_delay_sel[3:0] == 4'h0)
         |-> chain_tap[3] == $past(casc_out[2]);
   endproperty
   a_link3: assert property (p_link3) else $error("Fourth table missed the carry.");

   property p_tap_first;
      @(posedge i_ref_clk) disable iff (i_rst)
      (chain && i_shift_en) ##1 (chain && i_delay_sel == 6'h00)
         |-> o_delay_out == $past(i_shift_cascade_in);
   endproperty
   a_tap_first: assert property (p_tap_first) else $error("One-cycle delay wrong.");

   property p_tap_mid16;
      @(posedge i_ref_clk) disable iff (i_rst)
      (chain && i_shift_en) ##1 (chain && i_delay_sel == 6'h10)
         |-> o_delay_out == $past(casc_out[0]);
   endproperty
   a_tap_mid16: assert property (p_tap_mid16) else $error("Delay of 17 wrong.");

   property p_tap_mid32;
      @(posedge i_ref_clk) disable iff (i_rst)
      (chain && i_shift_en) ##1 (chain && i_delay_sel == 6'h20)
         |-> o_delay_out == $past(casc_out[1]);
   endproperty
   a_tap_mid32: assert property (p_tap_mid32) else $error("Delay of 33 wrong.");

   property p_tap_last;
      @(posedge i_ref_clk) disable iff (i_rst)
      (chain && i_delay_sel == 6'h3F) |-> o_delay_out == o_shift_cascade_out;
   endproperty
   a_tap_last: assert property (p_tap_last) else $error("Delay of 64 wrong.");

   property p_chain_hold;
      @(posedge i_ref_clk) disable iff (i_rst)
      (chain && !i_shift_en) |=> o_shift_cascade_out == $past(o_shift_cascade_out);
   endproperty
   a_chain_hold: assert property (p_chain_hold) else $error("Chain moved without enable.");

   property p_ram_port2;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_left_mode == lfg_pkg::MODE_RAM && i_we[0]) ##1 (i_rd2_addr == $past(i_waddr))
         |-> o_rd2_data == $past(i_wdata);
   endproperty
   a_ram_port2: assert property (p_ram_port2) else $error("Second port missed a write.");

   property p_ram_pri;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_left_mode == lfg_pkg::MODE_RAM && i_we[0])
         ##1 (!chain && i_lut_select_inputs[3:0] == $past(i_waddr))
         |-> o_lut_result[0] == $past(i_wdata);
   endproperty
   a_ram_pri: assert property (p_ram_pri) else $error("Primary table missed a write.");

   property p_ram_sec;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_left_mode == lfg_pkg::MODE_RAM && i_we[1])
         ##1 (!chain && i_lut_select_inputs[7:4] == $past(i_waddr))
         |-> o_lut_result[1] == $past(i_wdata);
   endproperty
   a_ram_sec: assert property (p_ram_sec) else $error("Secondary table missed a write.");

   property p_ram_hold;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_left_mode == lfg_pkg::MODE_RAM && i_we == 2'h0) |=> $stable(o_shift_cascade_out);
   endproperty
   a_ram_hold: assert property (p_ram_hold) else $error("Memory changed without write.");

   property p_logic_hold;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_left_mode == lfg_pkg::MODE_LOGIC) |=> $stable(o_shift_cascade_out);
   endproperty
   a_logic_hold: assert property (p_logic_hold) else $error("Logic table changed.");

   property p_right_a;
      @(posedge i_ref_clk) disable iff (i_rst)
      o_lut_result[2] == INIT_ROM[i_lut_select_inputs[11:8]];
   endproperty
   a_right_a: assert property (p_right_a) else $error("First right table lost its ROM.");

   property p_right_b;
      @(posedge i_ref_clk) disable iff (i_rst)
      o_lut_result[3] == INIT_ROM[i_lut_select_inputs[15:12]];
   endproperty
   a_right_b: assert property (p_right_b) else $error("Second right table lost its ROM.");

   property p_rd2_same;
      @(posedge i_ref_clk) disable iff (i_rst)
      (!chain && i_rd2_addr == i_lut_select_inputs[3:0]) |-> o_rd2_data == o_lut_result[0];
   endproperty
   a_rd2_same: assert property (p_rd2_same) else $error("Read ports disagree.");

   property p_wide5_low;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_wide_sel[0] == 1'b0) |-> o_wide5_result == o_lut_result[0];
   endproperty
   a_wide5_low: assert property (p_wide5_low) else $error("Five-input mux wrong.");

   property p_wide_sel0;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_wide_sel == 2'h0) |-> o_wide6_result == o_lut_result[0];
   endproperty
   a_wide_sel0: assert property (p_wide_sel0) else $error("Six-input mux lane 0 wrong.");

   property p_wide_sel1;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_wide_sel == 2'h1) |-> o_wide6_result == o_lut_result[1];
   endproperty
   a_wide_sel1: assert property (p_wide_sel1) else $error("Six-input mux lane 1 wrong.");

   property p_wide_sel2;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_wide_sel == 2'h2) |-> o_wide6_result == o_lut_result[2];
   endproperty
   a_wide_sel2: assert property (p_wide_sel2) else $error("Six-input mux lane 2 wrong.");

   property p_wide_sel3;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_wide_sel == 2'h3) |-> o_wide6_result == o_lut_result[3];
   endproperty
   a_wide_sel3: assert property (p_wide_sel3) else $error("Six-input mux lane 3 wrong.");

endmodule
`default_nettype wire

// File: inc/lfg_pkg.sv
// Package of constants for the look-up-table function generator tile.
// Contract
// - Each slice holds two independent look-up tables, a primary and a secondary one.
// - Each table takes four select inputs, drives one result and can realise any 4-input function.
// - Wide-function multiplexers merge several table outputs into functions of more inputs.
// - Every table, left or right, can act as a read-only memory fixed at configuration.
// - Only left-hand tables support the memory and shift-register uses; right-hand ones do not.
// - A left-hand table used as distributed memory holds 16 bits, and tables combine for more.
// - A dual-port option pairs two tables so the data is reached through two independent lines; here one left-hand table has a second read port instead.
// - A left-hand table used as a shift register delays serial data by one to 16 cycles.
// - The four left-hand tables of one tile combine into one shift register of up to 64 cycles.
// - Shift tables chain through cascade in and out, which also spans more than one tile.
package lfg_pkg;
   localparam int LUT_SEL_W  = 4;
   localparam int LUT_DEPTH  = 16;
   localparam int TILE_LUTS  = 4;
   localparam int CHAIN_LEN  = 64;
   localparam logic [1:0] MODE_LOGIC = 2'h0;
   localparam logic [1:0] MODE_RAM   = 2'h1;
   localparam logic [1:0] MODE_SHIFT = 2'h2;
   localparam logic [15:0] INIT_ZERO = 16'h0000;
endpackage

// File: rtl/lfg_lut.sv
// One four-input look-up table with optional memory and shift uses.
`timescale 1ns/1ps
`default_nettype none
module lfg_lut #(
   parameter bit          LEFT_HAND = 1'b1,
   parameter logic [15:0] INIT      = lfg_pkg::INIT_ZERO
) (
   // Clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst,
   // Configuration
   input  wire logic [1:0] i_mode,
   // Select and result
   input  wire logic [3:0] i_lut_select_inputs,
   output logic            o_lut_result,
   // Write and shift
   input  wire logic       i_we,
   input  wire logic       i_wdata,
   input  wire logic [3:0] i_waddr,
   input  wire logic       i_shift_cascade_in,
   output logic            o_shift_cascade_out,
   // Second read port
   input  wire logic [3:0] i_rd2_addr,
   output logic            o_rd2_data
);
   logic [15:0] mem_q;
   logic [15:0] mem_d;
   logic        is_ram;
   logic        is_shift;
   // Right-hand tables ignore the memory and shift modes and stay as ROM.
   assign is_ram   = LEFT_HAND && (i_mode == lfg_pkg::MODE_RAM);
   assign is_shift = LEFT_HAND && (i_mode == lfg_pkg::MODE_SHIFT);
   // Shift advances one place; memory writes one addressed bit.
   assign mem_d = is_shift ? {mem_q[14:0], i_shift_cascade_in}
                : (is_ram ? (mem_q & ~(16'h0001 << i_waddr))
                          | ({15'h0000, i_wdata} << i_waddr) : mem_q);
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         mem_q <= INIT;
      end else if (i_we) begin
         mem_q <= mem_d;
      end
   end
   // Combinational read selects the function value or the tap for delay select+1.
   assign o_lut_result        = mem_q[i_lut_select_inputs];
   assign o_rd2_data          = mem_q[i_rd2_addr];
   assign o_shift_cascade_out = mem_q[15];
   property p_shift_adv;
      @(posedge i_ref_clk) disable iff (i_rst)
      (is_shift && i_we) |=> (mem_q[0] == $past(i_shift_cascade_in))
         && (mem_q[15:1] == $past(mem_q[14:0]));
   endproperty
   a_shift_adv: assert property (p_shift_adv) else $error("Shift did not advance.");
   property p_ram_write;
      @(posedge i_ref_clk) disable iff (i_rst)
      (is_ram && i_we) ##1 (i_lut_select_inputs == $past(i_waddr)) |-> o_lut_result == $past(i_wdata);
   endproperty
   a_ram_write: assert property (p_ram_write) else $error("Write not visible on read.");
   property p_right_fixed;
      @(posedge i_ref_clk) disable iff (i_rst)
      !LEFT_HAND |=> $stable(mem_q);
   endproperty
   a_right_fixed: assert property (p_right_fixed) else $error("Right-hand table changed.");
   property p_dual;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_rd2_addr == i_lut_select_inputs) |-> o_rd2_data == o_lut_result;
   endproperty
   a_dual: assert property (p_dual) else $error("Ports disagree.");
   property p_rom_hold;
      @(posedge i_ref_clk) disable iff (i_rst)
      !(is_ram || is_shift) |=> $stable(mem_q);
   endproperty
   a_rom_hold: assert property (p_rom_hold) else $error("Table changed outside memory use.");
endmodule
`default_nettype wire

// File: tb/lfg_user_src.sv
// Fabric-side source that feeds the tile's shift chain, with random stalls.
`timescale 1ns/1ps
`default_nettype none
module lfg_user_src (
   // Clock and control
   input  wire logic i_ref_clk,
   input  wire logic i_go,
   // Stream toward the tile
   output logic      o_en,
   output logic      o_bit
);
   initial begin
      o_en = 1'b0;
      o_bit = 1'b0;
   end
   always @(negedge i_ref_clk) begin
      o_en <= i_go && $urandom_range(0, 3) != 0;
      o_bit <= 1'($urandom_range(0, 1));
   end
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench of the logic tile against a queue-based model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin n_compared++; if ((e) !== (a)) begin err_total++; \
   $display("mismatch %s exp %0h got %0h", n, e, a); end end
module testbench;
   localparam logic [15:0] ROM = 16'hA5C3;
   logic        i_ref_clk, i_rst, i_wdata, i_shift_en, i_shift_cascade_in, go;
   logic [1:0]  i_left_mode, i_right_mode, i_wide_sel, i_we;
   logic [15:0] i_lut_select_inputs, m0, m1;
   logic [3:0]  i_waddr, i_rd2_addr, o_lut_result;
   logic [5:0]  i_delay_sel;
   logic        o_rd2_data, o_delay_out, o_shift_cascade_out;
   logic        o_wide5_result, o_wide6_result, e5, e6;
   logic        hist[$];
   int          err_total, n_compared, cyc;
   lfg_tile #(.INIT_ROM(ROM)) uut (.i_ref_clk, .i_rst, .i_left_mode, .i_right_mode,
      .i_lut_select_inputs, .o_lut_result, .i_wide_sel, .o_wide5_result,
      .o_wide6_result, .i_we, .i_wdata, .i_waddr, .i_rd2_addr, .o_rd2_data,
      .i_shift_en, .i_shift_cascade_in, .i_delay_sel, .o_delay_out, .o_shift_cascade_out);
   lfg_user_src src (.i_ref_clk, .i_go(go), .o_en(i_shift_en), .o_bit(i_shift_cascade_in));
   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   always @(posedge i_ref_clk) begin
      if (!i_rst && i_left_mode == 2'h1 && i_we[0]) m0[i_waddr] <= i_wdata;
      if (!i_rst && i_left_mode == 2'h1 && i_we[1]) m1[i_waddr] <= i_wdata;
      if (!i_rst && i_left_mode == 2'h2 && i_shift_en) hist.push_front(i_shift_cascade_in);
      if (hist.size() > 64) void'(hist.pop_back());
      cyc <= cyc + 1;
      if (cyc == 1000) begin
         err_total++;
         close_out;
      end
   end
   initial begin
      {i_rst, go, m0, m1} = {2'h2, ROM, ROM};
      {i_left_mode, i_right_mode, i_wide_sel, i_we, i_wdata} = 9'h000;
      {i_lut_select_inputs, i_waddr, i_rd2_addr, i_delay_sel} = 30'h0;
      void'($urandom(24380));
      repeat (6) @(posedge i_ref_clk);
      @(negedge i_ref_clk) i_rst = 1'b0;
      for (int k = 0; k < 640; k++) begin
         @(negedge i_ref_clk);
         i_left_mode = k < 40 ? 2'h0 : (k < 240 ? 2'h1 : 2'h2);
         go = k >= 240;
         i_right_mode = 2'($urandom_range(0, 2));
         {i_we, i_wdata, i_waddr, i_rd2_addr} = 11'($urandom);
         {i_lut_select_inputs, i_delay_sel, i_wide_sel} = 24'($urandom);
         #1;
         `CHK("right0", ROM[i_lut_select_inputs[11:8]], o_lut_result[2])
         `CHK("right1", ROM[i_lut_select_inputs[15:12]], o_lut_result[3])
         if (i_left_mode != 2'h2) begin
            `CHK("left0", m0[i_lut_select_inputs[3:0]], o_lut_result[0])
            `CHK("left1", m1[i_lut_select_inputs[7:4]], o_lut_result[1])
            `CHK("rd2", m0[i_rd2_addr], o_rd2_data)
            e5 = i_wide_sel[0] ? m1[i_lut_select_inputs[7:4]] : m0[i_lut_select_inputs[3:0]];
            e6 = i_wide_sel[0] ? ROM[i_lut_select_inputs[15:12]] : ROM[i_lut_select_inputs[11:8]];
            `CHK("wide5", e5, o_wide5_result)
            `CHK("wide6", i_wide_sel[1] ? e6 : e5, o_wide6_result)
         end else if (hist.size() == 64) begin
            `CHK("delay", hist[i_delay_sel], o_delay_out)
            `CHK("cascade", hist[63], o_shift_cascade_out)
         end
      end
      close_out;
   end
endmodule
`default_nettype wire
